// ==== efm_pkg.sv ====
// Functional notes
// - report event only if its mask weight set
// - start outputs weigh 1..128, mask 85
// - trip outputs weigh 1..128, mask 85
// - recovery events weigh 1..16, mask 11
// - event register overflow raises its own event
// - system events always reported, never masked
// - every setting write is range checked
// - out of range value ignored, old kept
// - bus setting writes need password 1..999
// - matching value on open parameter opens
// - writing close parameter closes password
// - power interruption closes password
// - panel password entry overwrites stored one
// - seven wrong tries zero and lock password
// - bus writes only to writable parameters
// - data, settings and status readable by bus
package efm_pkg;

  // ***************************************************
  // parameter numbers and limits
  // ***************************************************
  localparam logic [7:0]  PRM_START_MASK = 8'h9D;
  localparam logic [7:0]  PRM_TRIP_MASK  = 8'h9E;
  localparam logic [7:0]  PRM_REC_MASK   = 8'h9F;
  localparam logic [7:0]  PRM_PW_OPEN    = 8'hA0;
  localparam logic [7:0]  PRM_PW_CLOSE   = 8'hA1;
  localparam logic [7:0]  PRM_OUT_STATE  = 8'h01;
  localparam logic [7:0]  PRM_PW_STATE   = 8'h02;
  localparam logic [7:0]  START_MASK_RST = 8'h55;
  localparam logic [7:0]  TRIP_MASK_RST  = 8'h55;
  localparam logic [4:0]  REC_MASK_RST   = 5'h0B;
  localparam logic [15:0] OUT_MASK_MAX   = 16'h00FF;
  localparam logic [15:0] REC_MASK_MAX   = 16'h001F;
  localparam logic [15:0] PW_MIN         = 16'h0001;
  localparam logic [15:0] PW_MAX         = 16'h03E7;
  localparam logic [9:0]  PW_RST         = 10'h001;
  localparam logic [9:0]  PW_ZERO        = 10'h000;
  localparam logic [2:0]  PW_TRIES       = 3'h7;

  // ***************************************************
  // event register layout and codes
  // ***************************************************
  localparam int          EV_NUM        = 23;
  localparam int          EV_TRIP_BASE  = 8;
  localparam int          EV_REC_BASE   = 16;
  localparam int          EV_RESTART    = 21;
  localparam int          EV_OVERFLOW   = 22;
  localparam logic [22:0] EV_PEND_RST   = 23'h200000;
  localparam logic [7:0]  CODE_EV_BASE  = 8'h19;
  localparam logic [7:0]  CODE_SYS_BASE = 8'h32;

  typedef enum logic [2:0] {
    PW_CLOSED = 3'b001,
    PW_OPENED = 3'b010,
    PW_LOCKED = 3'b100
  } efm_pw_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  param;
    logic [15:0] data;
  } efm_req_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] data;
  } efm_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } efm_evt_t;

endpackage : efm_pkg

// ==== efm_event_gate.sv ====
`timescale 1ns/10ps
module efm_event_gate (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic [3:0]      startOut,
  input  wire logic [3:0]      tripOut,
  input  wire logic [4:0]      recEvent,
  input  wire logic            powerFail,
  input  wire efm_pkg::efm_req_t busReq,
  output efm_pkg::efm_rsp_t    busRsp,
  input  wire efm_pkg::efm_req_t panelReq,
  output efm_pkg::efm_evt_t    evOut,
  input  wire logic            evReady,
  output logic                 pwOpen
);

  // ***************************************************
  // helpers
  // ***************************************************
  // lowest pending event index
  function automatic logic [4:0] firstIdx(input logic [22:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = efm_pkg::EV_NUM - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : firstIdx

  // event index to transmitted code
  function automatic logic [7:0] codeOf(input logic [4:0] idx);
    logic [7:0] r;
    if (idx < 5'(efm_pkg::EV_RESTART)) begin
      r = efm_pkg::CODE_EV_BASE + {3'h0, idx};
    end else begin
      r = efm_pkg::CODE_SYS_BASE + {3'h0, idx} - 8'(efm_pkg::EV_RESTART);
    end
    return r;
  endfunction : codeOf

  // ***************************************************
  // state
  // ***************************************************
  logic [7:0]        startMask, next_startMask;
  logic [7:0]        tripMask,  next_tripMask;
  logic [4:0]        recMask,   next_recMask;
  logic [9:0]        pwValue,   next_pwValue;
  logic [2:0]        tries,     next_tries;
  efm_pkg::efm_pw_t  pwState,   next_pwState;
  efm_pkg::efm_rsp_t next_busRsp;
  logic [3:0]        prevStart, prevTrip;
  logic [22:0]       pending,   next_pending;
  logic [22:0]       newEv,     taken;
  logic              ovf,       takeOk;
  efm_pkg::efm_evt_t next_evOut;

  assign pwOpen = (pwState == efm_pkg::PW_OPENED);

  // ***************************************************
  // event capture and output
  // ***************************************************
  // edge detect, weight mask, overflow, pick next
  always_comb begin
    newEv = '0;
    for (int k = 0; k < 4; k++) begin
      newEv[2*k]   = startOut[k] & ~prevStart[k] & startMask[2*k];
      newEv[2*k+1] = ~startOut[k] & prevStart[k] & startMask[2*k+1];
      newEv[efm_pkg::EV_TRIP_BASE+2*k]   = tripOut[k] & ~prevTrip[k]
                                           & tripMask[2*k];
      newEv[efm_pkg::EV_TRIP_BASE+2*k+1] = ~tripOut[k] & prevTrip[k]
                                           & tripMask[2*k+1];
    end
    for (int j = 0; j < 5; j++) begin
      newEv[efm_pkg::EV_REC_BASE+j] = recEvent[j] & recMask[j];
    end
    takeOk = ~evOut.valid | evReady;
    taken  = '0;
    next_evOut = evOut;
    if (takeOk) begin
      next_evOut.valid = 1'b0;
      if (|pending) begin
        taken[firstIdx(pending)] = 1'b1;
        next_evOut.valid = 1'b1;
        next_evOut.code  = codeOf(firstIdx(pending));
      end
    end
    // a repeat that finds its bit still waiting is lost
    ovf = |(newEv & pending & ~taken);
    next_pending = (pending & ~taken) | newEv;
    if (ovf) begin
      next_pending[efm_pkg::EV_OVERFLOW] = 1'b1;
    end
  end

  // event registers, restart pending after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prevStart <= 4'h0;
      prevTrip  <= 4'h0;
      pending   <= efm_pkg::EV_PEND_RST;
      evOut     <= '0;
    end else begin
      prevStart <= startOut;
      prevTrip  <= tripOut;
      pending   <= next_pending;
      evOut     <= next_evOut;
    end
  end

  // ***************************************************
  // parameter access and password
  // ***************************************************
  // bus requests, then panel, then power fail
  always_comb begin
    next_startMask = startMask;
    next_tripMask  = tripMask;
    next_recMask   = recMask;
    next_pwValue   = pwValue;
    next_tries     = tries;
    next_pwState   = pwState;
    next_busRsp    = '0;
    if (busReq.valid) begin
      next_busRsp.valid = 1'b1;
      if (busReq.write) begin
        case (busReq.param)
          efm_pkg::PRM_START_MASK, efm_pkg::PRM_TRIP_MASK: begin
            if (pwState != efm_pkg::PW_OPENED) begin
              next_busRsp.err = 1'b1;
            end else if (busReq.data > efm_pkg::OUT_MASK_MAX) begin
              next_busRsp.err = 1'b1;
            end else if (busReq.param == efm_pkg::PRM_START_MASK) begin
              next_startMask = busReq.data[7:0];
            end else begin
              next_tripMask = busReq.data[7:0];
            end
          end
          efm_pkg::PRM_REC_MASK: begin
            if (pwState != efm_pkg::PW_OPENED) begin
              next_busRsp.err = 1'b1;
            end else if (busReq.data > efm_pkg::REC_MASK_MAX) begin
              next_busRsp.err = 1'b1;
            end else begin
              next_recMask = busReq.data[4:0];
            end
          end
          efm_pkg::PRM_PW_OPEN: begin
            if (pwState == efm_pkg::PW_LOCKED) begin
              next_busRsp.err = 1'b1;
            end else if (busReq.data == {6'h00, pwValue}) begin
              next_pwState = efm_pkg::PW_OPENED;
              next_tries   = 3'h0;
            end else begin
              next_busRsp.err = 1'b1;
              next_tries      = tries + 3'h1;
              if (next_tries == efm_pkg::PW_TRIES) begin
                next_pwValue = efm_pkg::PW_ZERO;
                next_pwState = efm_pkg::PW_LOCKED;
                next_tries   = 3'h0;
              end
            end
          end
          efm_pkg::PRM_PW_CLOSE: begin
            // new value taken only while open
            if (pwState == efm_pkg::PW_OPENED &&
                busReq.data >= efm_pkg::PW_MIN &&
                busReq.data <= efm_pkg::PW_MAX) begin
              next_pwValue = busReq.data[9:0];
              next_tries   = 3'h0;
            end
            if (pwState == efm_pkg::PW_OPENED) begin
              next_pwState = efm_pkg::PW_CLOSED;
            end
          end
          default: begin
            next_busRsp.err = 1'b1;
          end
        endcase
      end else begin
        case (busReq.param)
          efm_pkg::PRM_START_MASK: next_busRsp.data = {8'h00, startMask};
          efm_pkg::PRM_TRIP_MASK:  next_busRsp.data = {8'h00, tripMask};
          efm_pkg::PRM_REC_MASK:   next_busRsp.data = {11'h000, recMask};
          efm_pkg::PRM_OUT_STATE:  next_busRsp.data = {8'h00, tripOut, startOut};
          efm_pkg::PRM_PW_STATE:   next_busRsp.data = {13'h0000, pwState};
          default:                 next_busRsp.err  = 1'b1;
        endcase
      end
    end
    // panel writes need no password, still range checked
    if (panelReq.valid && panelReq.write) begin
      case (panelReq.param)
        efm_pkg::PRM_START_MASK: begin
          if (panelReq.data <= efm_pkg::OUT_MASK_MAX) begin
            next_startMask = panelReq.data[7:0];
          end
        end
        efm_pkg::PRM_TRIP_MASK: begin
          if (panelReq.data <= efm_pkg::OUT_MASK_MAX) begin
            next_tripMask = panelReq.data[7:0];
          end
        end
        efm_pkg::PRM_REC_MASK: begin
          if (panelReq.data <= efm_pkg::REC_MASK_MAX) begin
            next_recMask = panelReq.data[4:0];
          end
        end
        efm_pkg::PRM_PW_CLOSE: begin
          if (panelReq.data >= efm_pkg::PW_MIN &&
              panelReq.data <= efm_pkg::PW_MAX) begin
            next_pwValue = panelReq.data[9:0];
            next_tries   = 3'h0;
            if (next_pwState == efm_pkg::PW_LOCKED) begin
              next_pwState = efm_pkg::PW_CLOSED;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (powerFail && next_pwState == efm_pkg::PW_OPENED) begin
      next_pwState = efm_pkg::PW_CLOSED;
    end
  end

  // setting and password registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      startMask <= efm_pkg::START_MASK_RST;
      tripMask  <= efm_pkg::TRIP_MASK_RST;
      recMask   <= efm_pkg::REC_MASK_RST;
      pwValue   <= efm_pkg::PW_RST;
      tries     <= 3'h0;
      pwState   <= efm_pkg::PW_CLOSED;
      busRsp    <= '0;
    end else begin
      startMask <= next_startMask;
      tripMask  <= next_tripMask;
      recMask   <= next_recMask;
      pwValue   <= next_pwValue;
      tries     <= next_tries;
      pwState   <= next_pwState;
      busRsp    <= next_busRsp;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  logic quiet;
  assign quiet = ~panelReq.valid & ~powerFail;

  a_start_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (startOut[0] && !prevStart[0] && startMask[0]) |=> pending[0])
    else $error("start rise not pending");

  a_trip_fall: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!tripOut[3] && prevTrip[3] && tripMask[7]) |=> pending[15])
    else $error("trip fall not pending");

  a_rec_event: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (recEvent[0] && recMask[0]) |=> pending[16])
    else $error("recovery event not pending");

  a_mask_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!startOut[0] && prevStart[0] && !startMask[1] && !pending[1]) |=> !pending[1])
    else $error("masked event reported");

  a_ovf_event: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (|(newEv & pending & ~taken)) |=> pending[22])
    else $error("overflow not raised");

  a_restart_ev: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !$past(rst_b) |-> pending[21] ##1 (evOut.valid && evOut.code == efm_pkg::CODE_SYS_BASE))
    else $error("restart not queued");

  a_range_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (busReq.valid && busReq.write && busReq.param == efm_pkg::PRM_START_MASK &&
     busReq.data > efm_pkg::OUT_MASK_MAX && quiet)
    |=> (busRsp.err && $stable(startMask)))
    else $error("out of range stored");

  a_closed_ro: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (busReq.valid && busReq.write && busReq.param == efm_pkg::PRM_REC_MASK &&
     !pwOpen && quiet) |=> (busRsp.err && $stable(recMask)))
    else $error("write taken while closed");

  a_open_match: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (busReq.valid && busReq.write && busReq.param == efm_pkg::PRM_PW_OPEN &&
     pwState != efm_pkg::PW_LOCKED && busReq.data == {6'h00, pwValue} && quiet)
    |=> (pwOpen && tries == 3'h0))
    else $error("matching password not opened");

  a_close_pw: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (busReq.valid && busReq.write && busReq.param == efm_pkg::PRM_PW_CLOSE) |=> !pwOpen)
    else $error("close did not close");

  a_power_close: assert property (@(posedge sys_clk) disable iff (!rst_b)
    powerFail |=> !pwOpen)
    else $error("power fail left open");

  a_lockout: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (busReq.valid && busReq.write && busReq.param == efm_pkg::PRM_PW_OPEN &&
     busReq.data != {6'h00, pwValue} && tries == efm_pkg::PW_TRIES - 3'h1 &&
     !pwOpen && quiet)
    |=> (pwState == efm_pkg::PW_LOCKED && pwValue == efm_pkg::PW_ZERO))
    else $error("seventh wrong try not locked");

  a_rsp_next: assert property (@(posedge sys_clk) disable iff (!rst_b)
    busReq.valid |=> busRsp.valid)
    else $error("no response");

endmodule : efm_event_gate

// ==== efm_bus_master.sv ====
`timescale 1ns/10ps
// ***************************************************
// serial bus master stand-in
// ***************************************************
module efm_bus_master (
  input  wire logic              sys_clk,
  output efm_pkg::efm_req_t      busReq,
  input  wire efm_pkg::efm_rsp_t busRsp
);
  // link status seen by the master, kept here and never made by the block
  logic linkLost = 1'b0;

  // idle bus at time zero
  initial busReq = '0;

  // one request, answer taken while it stands
  task automatic xfer(input  logic              wr,
                      input  logic [7:0]        prm,
                      input  logic [15:0]       dat,
                      output efm_pkg::efm_rsp_t rsp);
    @(negedge sys_clk);
    busReq = '{valid: 1'b1, write: wr, param: prm, data: dat};
    // taken at the next rising edge, answer registered on that same edge
    @(negedge sys_clk);
    rsp          = busRsp;
    linkLost     = ~rsp.valid;
    busReq.valid = 1'b0;
    busReq.data  = ~dat;  // released data does not linger
  endtask : xfer

  // new password: open current one, then write via close
  task automatic change_pw(input logic [15:0] oldPw,
                           input logic [15:0] newPw);
    efm_pkg::efm_rsp_t rsp;
    xfer(1'b1, efm_pkg::PRM_PW_OPEN, oldPw, rsp);
    xfer(1'b1, efm_pkg::PRM_PW_CLOSE, newPw, rsp);
  endtask : change_pw

endmodule : efm_bus_master

// ==== tb_event_mask_and_password_gate.sv ====
`timescale 1ns/10ps
module tb_event_mask_and_password_gate;
  logic              sys_clk = 1'b0;
  logic              rst_b;
  logic [3:0]        startOut;
  logic [3:0]        tripOut;
  logic [4:0]        recEvent;
  logic              powerFail;
  logic              evReady;
  logic              pwOpen;
  efm_pkg::efm_req_t busReq;
  efm_pkg::efm_req_t panelReq;
  efm_pkg::efm_rsp_t busRsp;
  efm_pkg::efm_evt_t evOut;
  efm_pkg::efm_rsp_t rsp;
  int                n_errors = 0;
  int                compares = 0;

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  efm_event_gate dut (.sys_clk(sys_clk), .rst_b(rst_b), .startOut(startOut),
    .tripOut(tripOut), .recEvent(recEvent), .powerFail(powerFail), .busReq(busReq),
    .busRsp(busRsp), .panelReq(panelReq), .evOut(evOut), .evReady(evReady),
    .pwOpen(pwOpen));
  efm_bus_master master (.sys_clk(sys_clk), .busReq(busReq), .busRsp(busRsp));

  // ***************************************************
  // shared helpers
  // ***************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] prm, input logic [15:0] dat, input logic err);
    master.xfer(1'b1, prm, dat, rsp);
    chk(master.linkLost, 1'b0);
    chk(rsp.err, err);
  endtask : wr

  task automatic rd(input logic [7:0] prm, input logic [15:0] exp);
    master.xfer(1'b0, prm, 16'h0000, rsp);
    chk(master.linkLost, 1'b0);
    chk(rsp.err, 1'b0);
    chk(rsp.data, exp);
  endtask : rd

  // wait for an event, check its code, take it
  task automatic ev(input logic [7:0] code);
    @(negedge sys_clk);
    for (int i = 0; i < 10 && evOut.valid !== 1'b1; i++) @(negedge sys_clk);
    chk(evOut.valid, 1'b1);
    chk(evOut.code, code);
    evReady = 1'b1;
    @(negedge sys_clk);
    evReady = 1'b0;
  endtask : ev

  task automatic noev(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      chk(evOut.valid, 1'b0);
    end
  endtask : noev

  task automatic panel(input logic [7:0] prm, input logic [15:0] dat);
    @(negedge sys_clk);
    panelReq = '{valid: 1'b1, write: 1'b1, param: prm, data: dat};
    @(negedge sys_clk);
    panelReq = '0;
  endtask : panel

  task automatic pulse_rec(input logic [4:0] r);
    @(negedge sys_clk);
    recEvent = r;
    @(negedge sys_clk);
    recEvent = 5'h00;
  endtask : pulse_rec

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset;
    ev(8'h32);
    rd(8'h9D, 16'h0055);
    rd(8'h9E, 16'h0055);
    rd(8'h9F, 16'h000B);
    rd(8'h02, 16'h0001);
  endtask : t_reset

  task automatic t_gate;
    wr(8'h9D, 16'h000F, 1'b1);
    rd(8'h9D, 16'h0055);
    wr(8'hA0, 16'h0002, 1'b1);
    wr(8'hA0, 16'h0001, 1'b0);
    chk(pwOpen, 1'b1);
  endtask : t_gate

  task automatic t_mask;
    @(negedge sys_clk) startOut = 4'h1;
    ev(8'h19);
    @(negedge sys_clk) startOut = 4'h0;
    noev(5);
    @(negedge sys_clk) tripOut = 4'h2;
    ev(8'h23);
    @(negedge sys_clk) tripOut = 4'h0;
    noev(5);
    pulse_rec(5'h08);
    ev(8'h2C);
    pulse_rec(5'h04);
    noev(5);
  endtask : t_mask

  task automatic t_range;
    wr(8'h9D, 16'h0100, 1'b1);
    wr(8'h9F, 16'h0020, 1'b1);
    rd(8'h9D, 16'h0055);
    wr(8'h9D, 16'h00FF, 1'b0);
    rd(8'h9D, 16'h00FF);
  endtask : t_range

  // second start fall event is lost while its bit still waits
  task automatic t_overflow;
    for (int k = 0; k < 4; k++) begin
      @(negedge sys_clk) startOut = (k % 2 == 0) ? 4'h1 : 4'h0;
      repeat (2) @(negedge sys_clk);
    end
    ev(8'h19);
    ev(8'h19);
    ev(8'h1A);
    ev(8'h33);
    noev(3);
  endtask : t_overflow

  task automatic t_close;
    wr(8'hA1, 16'h0005, 1'b0);
    chk(pwOpen, 1'b0);
    wr(8'hA0, 16'h0001, 1'b1);
    master.change_pw(16'h0005, 16'h0006);
    rd(8'h02, 16'h0001);
    wr(8'hA0, 16'h0006, 1'b0);
    @(negedge sys_clk) powerFail = 1'b1;
    @(negedge sys_clk) powerFail = 1'b0;
    chk(pwOpen, 1'b0);
  endtask : t_close

  task automatic t_lock;
    repeat (6) wr(8'hA0, 16'h0003, 1'b1);
    wr(8'hA0, 16'h0006, 1'b0);
    repeat (6) wr(8'hA0, 16'h0003, 1'b1);
    rd(8'h02, 16'h0002);
    wr(8'hA0, 16'h0003, 1'b1);
    rd(8'h02, 16'h0004);
    chk(pwOpen, 1'b0);
    wr(8'hA0, 16'h0000, 1'b1);
    panel(8'hA1, 16'h0009);
    rd(8'h02, 16'h0001);
    panel(8'h9E, 16'h0100);
    rd(8'h9E, 16'h0055);
    panel(8'h9F, 16'h0001);
    rd(8'h9F, 16'h0001);
    panel(8'h9D, 16'h0055);
    rd(8'h9D, 16'h0055);
    wr(8'hA0, 16'h0009, 1'b0);
  endtask : t_lock

  task automatic t_access;
    evReady = 1'b1;
    @(negedge sys_clk) tripOut = 4'h8;
    startOut = 4'h4;
    repeat (8) @(negedge sys_clk);
    evReady = 1'b0;
    rd(8'h01, 16'h0084);
    wr(8'h01, 16'h0001, 1'b1);
  endtask : t_access

  // ***************************************************
  // run control
  // ***************************************************
  task automatic summarize;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // watchdog well past the expected run
  initial begin
    #(8 * 3000);
    n_errors++;
    summarize();
  end

  // main sequence
  initial begin
    rst_b     = 1'b0;
    startOut  = 4'h0;
    tripOut   = 4'h0;
    recEvent  = 5'h00;
    powerFail = 1'b0;
    evReady   = 1'b0;
    panelReq  = '0;
    repeat (12) @(negedge sys_clk);
    rst_b = 1'b1;
    t_reset();
    t_gate();
    t_mask();
    t_range();
    t_overflow();
    t_close();
    t_lock();
    t_access();
    summarize();
  end
endmodule : tb_event_mask_and_password_gate
